// >>> src/psp_pkg.sv
package psp_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FAST_PARK_US = 32;
  localparam int unsigned NORMAL_PARK_MS = 20;
  localparam int unsigned REG_STOP_MS = 12;
  localparam int unsigned BOOT_MS = 100;
  localparam int unsigned FPGA_SETUP_US = 2750;
  localparam int unsigned FILTER_NS = 150;
  // longest times round down, least times round up
  localparam int unsigned FAST_PARK_CYC = FAST_PARK_US * CLK_MHZ;
  localparam int unsigned NORMAL_PARK_CYC = NORMAL_PARK_MS * 1000 * CLK_MHZ;
  localparam int unsigned REG_STOP_CYC = REG_STOP_MS * 1000 * CLK_MHZ;
  localparam int unsigned BOOT_CYC = BOOT_MS * 1000 * CLK_MHZ;
  localparam int unsigned FPGA_SETUP_CYC = FPGA_SETUP_US * CLK_MHZ;
  localparam int unsigned FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;
  // pll lock and flash load cycles, then cycles of the mirror park stepping inside the park windows
  localparam int unsigned PLL_LOCK_CYC = 64;
  localparam int unsigned FLASH_LOAD_CYC = 256;
  localparam int unsigned FAST_PARK_STEPS_CYC = 1000;
  localparam int unsigned NORMAL_PARK_STEPS_CYC = 100000;

  // ==========================================================================
  // sizes and reset values
  // ==========================================================================
  localparam int unsigned GPIO_W = 20;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned FLT_W = 8;
  localparam logic RST_IRQ = 1'b0;

  typedef enum logic [3:0] {
    PSP_HELD,
    PSP_PLL_LOCK,
    PSP_FLASH_LOAD,
    PSP_BOOT,
    PSP_FPGA_SETUP,
    PSP_RUN,
    PSP_NORMAL_PARK,
    PSP_REG_STOP,
    PSP_OFF,
    PSP_FAST_PARK,
    PSP_PARKED
  } psp_state_t;

endpackage

// >>> src/psp_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module psp_glitch_filter
  import psp_pkg::*;
#(
  parameter int unsigned STABLE_CYC = FILTER_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic raw_in,
  output logic filt_out
);

  logic [FLT_W-1:0] cnt_q;
  logic [FLT_W-1:0] cnt_d;
  logic filt_d;
  logic filt_q;

  // ==========================================================================
  // output only follows after a level held longer than the glitch filter window
  // ==========================================================================
  always_comb
  begin
    cnt_d = '0;
    filt_d = filt_q;
    if (raw_in != filt_q)
    begin
      if (cnt_q >= FLT_W'(STABLE_CYC))
        filt_d = raw_in;
      else
        cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      filt_q <= 1'b1; // idle level is no park request
    end
    else
    begin
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt_out = filt_q;

endmodule
`default_nettype wire

// >>> src/psp_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module psp_sequencer
  import psp_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC,
  parameter int unsigned FPGA_SETUP_CYCLES = FPGA_SETUP_CYC,
  parameter int unsigned NORMAL_PARK_CYCLES = NORMAL_PARK_STEPS_CYC,
  parameter int unsigned REG_STOP_CYCLES = REG_STOP_CYC,
  parameter int unsigned FAST_PARK_CYCLES = FAST_PARK_STEPS_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic active_low_reset_in_n,
  input wire logic fast_park_request_n,
  input wire logic projector_power_request,
  input wire logic pll_locked,
  input wire logic flash_load_done,
  output logic flash_serial_clock,
  output logic flash_serial_out,
  output logic flash_select_0_n,
  output logic flash_select_1_n,
  output logic flash_bus_oe_n,
  output logic [GPIO_W-1:0] gpio_out,
  output logic gpio_oe_n,
  output logic led_select_0,
  output logic led_select_1,
  output logic mirror_array_enable_reset_n,
  output logic init_status_irq,
  output logic pll_lock_request,
  output logic flash_load_request,
  output logic fpga_setup_active,
  output logic command_ready,
  output logic mirror_data_enable,
  output logic mirror_reg_enable,
  output logic park_done
);

  // ==========================================================================
  // request synchronisers and park input filter
  // ==========================================================================
  logic proj_s1_q;
  logic proj_s2_q;
  logic park_s1_q;
  logic park_s2_q;
  logic park_filt;
  logic proj_prev_q;
  logic park_prev_q;

  // two stages each; only the second stage is looked at
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      proj_s1_q <= 1'b0;
      proj_s2_q <= 1'b0;
      park_s1_q <= 1'b1;
      park_s2_q <= 1'b1;
    end
    else
    begin
      proj_s1_q <= projector_power_request;
      proj_s2_q <= proj_s1_q;
      park_s1_q <= fast_park_request_n;
      park_s2_q <= park_s1_q;
    end
  end

  // short pulses on the park input, up to FILTER_CYC cycles, are ignored
  psp_glitch_filter #(
    .STABLE_CYC(FILTER_CYC)
  ) u_park_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw_in(park_s2_q),
    .filt_out(park_filt)
  );

  // ==========================================================================
  // sequence state machine
  // ==========================================================================
  psp_state_t state_q;
  psp_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic held;
  logic park_fall;
  logic proj_fall;

  assign held = ~active_low_reset_in_n;
  assign park_fall = park_prev_q & ~park_filt;
  assign proj_fall = proj_prev_q & ~proj_s2_q;

  // next state: boot order, parks, fast park overrides everything
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + 32'h1;
    case (state_q)
      PSP_HELD:
      begin
        cnt_d = '0;
        state_d = PSP_PLL_LOCK;
      end
      PSP_PLL_LOCK:
      begin
        cnt_d = '0;
        if (pll_locked)
          state_d = PSP_FLASH_LOAD;
      end
      PSP_FLASH_LOAD:
      begin
        cnt_d = '0;
        if (flash_load_done)
          state_d = PSP_BOOT;
      end
      PSP_BOOT:
        if (cnt_q >= CNT_W'(BOOT_CYCLES - 1))
        begin
          cnt_d = '0;
          state_d = PSP_FPGA_SETUP;
        end
      PSP_FPGA_SETUP:
        if (cnt_q >= CNT_W'(FPGA_SETUP_CYCLES - 1))
        begin
          cnt_d = '0;
          state_d = PSP_RUN;
        end
      PSP_RUN:
      begin
        cnt_d = '0;
        if (proj_fall || !proj_s2_q)
          state_d = PSP_NORMAL_PARK;
      end
      PSP_NORMAL_PARK:
        if (cnt_q >= CNT_W'(NORMAL_PARK_CYCLES - 1))
        begin
          cnt_d = '0;
          state_d = PSP_REG_STOP;
        end
      PSP_REG_STOP:
        if (cnt_q >= CNT_W'(REG_STOP_CYCLES - 1))
        begin
          cnt_d = '0;
          state_d = PSP_OFF;
        end
      PSP_OFF:
      begin
        cnt_d = '0;
        if (proj_s2_q)
          state_d = PSP_BOOT;
      end
      PSP_FAST_PARK:
        if (cnt_q >= CNT_W'(FAST_PARK_CYCLES - 1))
        begin
          cnt_d = '0;
          state_d = PSP_PARKED;
        end
      PSP_PARKED:
        cnt_d = '0;
      default:
      begin
        cnt_d = '0;
        state_d = PSP_HELD;
      end
    endcase
    if (park_fall && state_q != PSP_FAST_PARK && state_q != PSP_PARKED)
    begin
      cnt_d = '0;
      state_d = PSP_FAST_PARK;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || held)
    begin
      state_q <= PSP_HELD;
      cnt_q <= '0;
      proj_prev_q <= 1'b0;
      park_prev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      proj_prev_q <= proj_s2_q;
      park_prev_q <= park_filt;
    end
  end

  // ==========================================================================
  // registered outputs
  // ==========================================================================
  logic irq_d;
  logic run_d;
  logic reg_en_d;

  // interrupt high from release until initialization completes
  always_comb
  begin
    irq_d = 1'b0;
    case (state_d)
      PSP_PLL_LOCK, PSP_FLASH_LOAD, PSP_BOOT, PSP_FPGA_SETUP:
        irq_d = 1'b1;
      default:
        irq_d = 1'b0;
    endcase
    run_d = (state_d == PSP_RUN) && proj_s2_q;
    // regulation keeps running through the wait that follows a normal park
    reg_en_d = (state_d == PSP_RUN) || (state_d == PSP_NORMAL_PARK) || (state_d == PSP_REG_STOP) ||
      (state_d == PSP_FAST_PARK) || (state_d == PSP_FPGA_SETUP);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || held)
    begin
      flash_bus_oe_n <= 1'b1;
      gpio_oe_n <= 1'b1;
      flash_serial_clock <= 1'b0;
      flash_serial_out <= 1'b0;
      flash_select_0_n <= 1'b1;
      flash_select_1_n <= 1'b1;
      gpio_out <= '0;
      led_select_0 <= 1'b0;
      led_select_1 <= 1'b0;
      mirror_array_enable_reset_n <= 1'b0;
      init_status_irq <= RST_IRQ;
      pll_lock_request <= 1'b0;
      flash_load_request <= 1'b0;
      fpga_setup_active <= 1'b0;
      command_ready <= 1'b0;
      mirror_data_enable <= 1'b0;
      mirror_reg_enable <= 1'b0;
      park_done <= 1'b0;
    end
    else
    begin
      flash_bus_oe_n <= 1'b0;
      gpio_oe_n <= 1'b0;
      flash_serial_clock <= 1'b0;
      flash_serial_out <= 1'b0;
      flash_select_0_n <= ~(state_d == PSP_FLASH_LOAD);
      flash_select_1_n <= 1'b1;
      gpio_out <= '0;
      led_select_0 <= run_d;
      led_select_1 <= run_d;
      mirror_array_enable_reset_n <= reg_en_d;
      init_status_irq <= irq_d;
      pll_lock_request <= (state_d == PSP_PLL_LOCK);
      flash_load_request <= (state_d == PSP_FLASH_LOAD);
      fpga_setup_active <= (state_d == PSP_FPGA_SETUP);
      command_ready <= (state_d == PSP_RUN);
      mirror_data_enable <= run_d;
      mirror_reg_enable <= reg_en_d;
      park_done <= (state_d == PSP_REG_STOP) || (state_d == PSP_OFF) || (state_d == PSP_PARKED);
    end
  end

endmodule
`default_nettype wire

// >>> dv/psp_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port checker for the sequencer
module psp_seq_sva
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic active_low_reset_in_n,
  input wire logic fast_park_request_n,
  input wire logic projector_power_request,
  input wire logic flash_bus_oe_n,
  input wire logic gpio_oe_n,
  input wire logic led_select_0,
  input wire logic led_select_1,
  input wire logic mirror_array_enable_reset_n,
  input wire logic init_status_irq,
  input wire logic pll_lock_request,
  input wire logic flash_load_request,
  input wire logic command_ready,
  input wire logic park_done
);
  localparam int NP_MAX = 1000;
  logic [7:0] low_q;
  logic [11:0] fp_q;
  // cycles the raw park request has stayed low, saturating
  always_ff @(posedge clk_sys)
  begin
    if (rst || fast_park_request_n)
      low_q <= 8'h00;
    else if (low_q != 8'hff)
      low_q <= low_q + 8'h01;
  end
  // same count over the whole fast park window, saturating
  always_ff @(posedge clk_sys)
  begin
    if (rst || fast_park_request_n)
      fp_q <= 12'h000;
    else if (fp_q != 12'hfff)
      fp_q <= fp_q + 12'h001;
  end
  property p_float;
    @(posedge clk_sys) disable iff (rst) !active_low_reset_in_n |=> flash_bus_oe_n && gpio_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("pins driven while reset held");
  property p_low;
    @(posedge clk_sys) disable iff (rst) !active_low_reset_in_n |=> !led_select_0 && !led_select_1 && !mirror_array_enable_reset_n;
  endproperty
  a_low: assert property (p_low) else $error("led or mirror enable high in reset");
  property p_order;
    @(posedge clk_sys) disable iff (rst || !active_low_reset_in_n) $rose(flash_load_request) |-> $past(pll_lock_request);
  endproperty
  a_order: assert property (p_order) else $error("flash load before pll lock");
  property p_irq_up;
    @(posedge clk_sys) disable iff (rst) !active_low_reset_in_n ##1 active_low_reset_in_n |=> init_status_irq && pll_lock_request;
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("status not high after release");
  property p_irq_dn;
    @(posedge clk_sys) disable iff (rst || !active_low_reset_in_n) $fell(init_status_irq) |-> command_ready;
  endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("status low before init done");
  property p_fast;
    @(posedge clk_sys) disable iff (rst || !active_low_reset_in_n) fp_q == 12'hf9f |-> park_done; // 3999 cycles
  endproperty
  a_fast: assert property (p_fast) else $error("fast park too slow");
  property p_filter;
    @(posedge clk_sys) disable iff (rst || !active_low_reset_in_n) $fell(command_ready) && projector_power_request |-> low_q >= 8'h13;
  endproperty
  a_filter: assert property (p_filter) else $error("short park pulse acted on");
  property p_normal;
    @(posedge clk_sys) disable iff (rst || !active_low_reset_in_n) $fell(projector_power_request) && command_ready |-> ##[1:NP_MAX] park_done;
  endproperty
  a_normal: assert property (p_normal) else $error("normal park too slow");
endmodule
bind psp_sequencer psp_seq_sva chk_u (.clk_sys, .rst, .active_low_reset_in_n, .fast_park_request_n,
  .projector_power_request, .flash_bus_oe_n, .gpio_oe_n, .led_select_0, .led_select_1,
  .mirror_array_enable_reset_n, .init_status_irq, .pll_lock_request, .flash_load_request,
  .command_ready, .park_done);
`default_nettype wire

// >>> dv/psp_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// power monitor, pll, flash and host side
module psp_partner
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic powered,
  input wire logic fault,
  input wire logic host_on,
  input wire logic [3:0] lat,
  input wire logic init_status_irq,
  input wire logic pll_lock_request,
  input wire logic flash_load_request,
  output logic active_low_reset_in_n,
  output logic fast_park_request_n,
  output logic projector_power_request,
  output logic pll_locked,
  output logic flash_load_done
);
  logic [3:0] hold_q;
  logic [3:0] wait_q;
  // hold counts only with power good and no fault, then stays released until power drops
  always_ff @(posedge clk_sys)
  begin
    if (rst || !powered)
      hold_q <= 4'h0;
    else if (hold_q != 4'h8 && !fault)
      hold_q <= hold_q + 4'h1;
    if (pll_locked || flash_load_done || !(pll_lock_request || flash_load_request))
      wait_q <= 4'h0;
    else if (wait_q != lat)
      wait_q <= wait_q + 4'h1;
    projector_power_request <= host_on || (projector_power_request && init_status_irq);
  end
  assign active_low_reset_in_n = (hold_q == 4'h8);
  assign fast_park_request_n = !fault;
  // lock and load answer after lat cycles
  assign pll_locked = pll_lock_request && (wait_q == lat);
  assign flash_load_done = flash_load_request && (wait_q == lat);
endmodule
`default_nettype wire

// >>> dv/power_sequence_park_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// sequencer testbench
module power_sequence_park_control_tb
  import psp_pkg::*;
;
  localparam int NP = 30;
  localparam int RS = 20;
  typedef struct { logic [3:0] lat; logic led; } psp_row_t;
  psp_row_t rows [2] = '{'{4'h0, 1'b1}, '{4'h9, 1'b1}};
  logic clk_sys = 1'b0, rst = 1'b1, powered = 1'b0, fault = 1'b0, host_on = 1'b0;
  logic [3:0] lat = 4'h0;
  logic active_low_reset_in_n, fast_park_request_n, projector_power_request, pll_locked, flash_load_done;
  logic flash_serial_clock, flash_serial_out, flash_select_0_n, flash_select_1_n, flash_bus_oe_n, gpio_oe_n;
  logic led_select_0, led_select_1, mirror_array_enable_reset_n, init_status_irq, pll_lock_request;
  logic flash_load_request, fpga_setup_active, command_ready, mirror_data_enable, mirror_reg_enable, park_done;
  logic [GPIO_W-1:0] gpio_out;
  logic [4:0] mon;
  int err_count = 0, n_tests = 0, n, i;
  assign mon = {park_done, init_status_irq, fpga_setup_active, flash_load_done, pll_lock_request};
  always #4 clk_sys = ~clk_sys;
  psp_partner pm_u (.clk_sys, .rst, .powered, .fault, .host_on, .lat, .init_status_irq, .pll_lock_request,
    .flash_load_request, .active_low_reset_in_n, .fast_park_request_n, .projector_power_request, .pll_locked,
    .flash_load_done);
  psp_sequencer #(.BOOT_CYCLES(50), .FPGA_SETUP_CYCLES(20), .NORMAL_PARK_CYCLES(NP), .REG_STOP_CYCLES(RS),
    .FAST_PARK_CYCLES(10)) dut_u (.clk_sys, .rst, .active_low_reset_in_n, .fast_park_request_n,
    .projector_power_request, .pll_locked, .flash_load_done, .flash_serial_clock, .flash_serial_out,
    .flash_select_0_n, .flash_select_1_n, .flash_bus_oe_n, .gpio_out, .gpio_oe_n, .led_select_0, .led_select_1,
    .mirror_array_enable_reset_n, .init_status_irq, .pll_lock_request, .flash_load_request, .fpga_setup_active,
    .command_ready, .mirror_data_enable, .mirror_reg_enable, .park_done);
  // verdict and end of run
  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // bounded wait for monitor bit k to reach v, n counts cycles
  task wt(input int k, input logic v, input int m);
    #1;
    for (n = 0; n < m && mon[k] !== v; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (mon[k] !== v)
    begin
      err_count++;
      $display("[ERR] wait %0d expected %h seen %h", k, v, mon[k]);
      stop_test();
    end
  endtask
  // power up and run the start sequence
  task boot(input logic [3:0] l);
    @(posedge clk_sys);
    lat <= l;
    powered <= 1'b1;
    host_on <= 1'b1;
    wt(0, 1'b1, 40);
    chk("irq_start", 1, init_status_irq);
    wt(1, 1'b1, 40);
    chk("fsel0", 0, flash_select_0_n);
    wt(2, 1'b1, 80);
    chk("boot_len", 1, n >= 49 && n <= 53);
    wt(3, 1'b0, 40);
    chk("setup_len", 1, n >= 19 && n <= 22);
    chk("cmd_ready", 1, command_ready);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      boot(rows[i].lat);
      chk("led0", rows[i].led, led_select_0);
      chk("data_en", 1, mirror_data_enable);
      chk("gpio_oe_run", 0, gpio_oe_n);
      chk("gpio_run", 0, gpio_out);
      chk("fsel1_run", 1, flash_select_1_n);
      chk("fclk_run", 0, {flash_serial_clock, flash_serial_out});
      @(posedge clk_sys);
      host_on <= 1'b0;
      wt(4, 1'b1, NP + 20);
      chk("np_len", 1, n <= NP + 8);
      chk("reg_on", 1, mirror_reg_enable);
      repeat (RS - 1) @(posedge clk_sys);
      #1;
      chk("reg_hold", 1, mirror_reg_enable);
      @(posedge clk_sys);
      #1;
      chk("reg_en", 0, mirror_reg_enable);
      chk("mirror_off", 0, mirror_array_enable_reset_n);
      @(posedge clk_sys);
      powered <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("flash_oe_n", 1, flash_bus_oe_n);
      chk("gpio_oe_n", 1, gpio_oe_n);
      chk("mirror_en", 0, mirror_array_enable_reset_n);
      chk("led1", 0, led_select_1);
    end
    boot(4'h2);
    @(posedge clk_sys);
    fault <= 1'b1;
    repeat (10) @(posedge clk_sys);
    fault <= 1'b0;
    repeat (40) @(posedge clk_sys);
    #1;
    chk("glitch", 1, command_ready);
    @(posedge clk_sys);
    fault <= 1'b1;
    wt(4, 1'b1, 4000);
    chk("fp_cmd", 0, command_ready);
    chk("fp_mirror", 0, mirror_data_enable);
    chk("fp_reg", 0, mirror_reg_enable);
    repeat (4000) @(posedge clk_sys);
    #1;
    chk("fp_stays", 1, park_done);
    stop_test();
  end
endmodule
`default_nettype wire
